// *** logic/sece_params.svh ***
// Constants of the serial EEPROM command engine
`ifndef SECE_PARAMS_SVH
`define SECE_PARAMS_SVH

`define SECE_ROWS 128
`define SECE_ADDR_W 8
`define SECE_ROW_W 16
`define SECE_AW16 7
`define SECE_AW8 8
`define SECE_DW16 16
`define SECE_DW8 8
`define SECE_OPC_BITS 2
`define SECE_ERASED_WORD 16'hffff
`define SECE_OP_SPECIAL 2'h0
`define SECE_OP_WRITE 2'h1
`define SECE_OP_READ 2'h2
`define SECE_OP_ERASE 2'h3
`define SECE_SP_LOCK 2'h0
`define SECE_SP_FILL 2'h1
`define SECE_SP_CLEAR 2'h2
`define SECE_SP_UNLOCK 2'h3
`define SECE_PROG_TIME_NS 10000000
`define SECE_CLK_PERIOD_NS 100
`define SECE_PROG_CYCLES (`SECE_PROG_TIME_NS / `SECE_CLK_PERIOD_NS)

`endif

// *** logic/sece_pkg.sv ***
// Types of the serial EEPROM command engine
package sece_pkg;

  typedef enum logic [5:0] {
    SECE_ST_IDLE = 6'h01,
    SECE_ST_RX = 6'h02,
    SECE_ST_DATA = 6'h04,
    SECE_ST_READ = 6'h08,
    SECE_ST_WAITCS = 6'h10,
    SECE_ST_DONE = 6'h20
  } sece_state_t;

  typedef enum logic [2:0] {
    SECE_PG_NONE = 3'h0,
    SECE_PG_WORD_WR = 3'h1,
    SECE_PG_WORD_ER = 3'h2,
    SECE_PG_ALL_WR = 3'h3,
    SECE_PG_ALL_ER = 3'h4
  } sece_prog_t;

endpackage : sece_pkg

// *** logic/sece_stream_if.sv ***
// Valid/ready word stream between the fetch side and the output shifter
`timescale 1ns/100ps
`default_nettype none
interface sece_stream_if #(
  parameter int WIDTH = 16
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sece_stream_if
`default_nettype wire

// *** logic/sece_buffer.sv ***
// Two-entry buffer for read words
`timescale 1ns/100ps
`default_nettype none
module sece_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic flush,
  sece_stream_if.snk fill,
  sece_stream_if.src drain
);
  logic [WIDTH-1:0] ent_reg [0:1];
  logic [WIDTH-1:0] ent_next [0:1];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic push;
  logic pop;

  assign fill.ready = (cnt_reg != 2'h2);
  assign drain.valid = (cnt_reg != 2'h0);
  assign drain.data = ent_reg[0];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_comb begin
    ent_next[0] = ent_reg[0];
    ent_next[1] = ent_reg[1];
    cnt_next = cnt_reg;
    if (flush) begin
      cnt_next = 2'h0;
    end else begin
      if (pop) begin
        ent_next[0] = ent_reg[1];
      end
      if (push) begin
        if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) begin
          ent_next[0] = fill.data;
        end else begin
          ent_next[1] = fill.data;
        end
      end
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg <= 2'h0;
      ent_reg[0] <= '0;
      ent_reg[1] <= '0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      ent_reg[0] <= ent_next[0];
      ent_reg[1] <= ent_next[1];
    end
  end
endmodule : sece_buffer
`default_nettype wire

// *** logic/sece_command_engine.sv ***
// Serial EEPROM command engine: instruction decode, array, programming timer
`timescale 1ns/100ps
`default_nettype none
`include "sece_params.svh"
// Functional notes
// - Strap high: 128 words of 16 bits, 7-bit address
// - Strap low: 256 words of 8 bits, 8-bit address
// - Start bit 1, opcode, address; read 10, write 01, erase 11; write carries data
// - Opcode 00: top address bits pick unlock, lock, fill all, clear all
// - Programming starts only while unlocked; otherwise array untouched
// - Locked after reset until unlock command
// - Word write self-timed, erase then program, no host clocks needed
// - After programming starts, raised chip select shows ready/busy on output
// - Read continues with following words while select high and clocks run
// - Stopped shift clock holds all sequence state
// - Single word erase and full array erase are self-timed cycles
// - Status bit 0 while busy, 1 when finished
// - Read gives one 0 bit, then data msb first on rising edges
// - Sequential read address wraps from last word to first
// - Erase leaves every affected bit at 1
module sece_command_engine #(
  parameter int PROG_CYCLES = `SECE_PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic chip_sel,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic word_width_strap,
  output logic serial_out,
  output logic serial_out_oe,
  output logic busy
);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sece_pkg::sece_state_t state_reg, state_next;
  sece_pkg::sece_prog_t pend_reg, pend_next;
  logic [25:0] rx_sh_reg, rx_sh_next;
  logic [4:0] rx_cnt_reg, rx_cnt_next;
  logic [7:0] addr_reg, addr_next;
  logic [15:0] data_reg, data_next;
  logic unlocked_reg, unlocked_next;
  logic busy_reg, busy_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic status_reg, status_next;
  logic [15:0] rd_sh_reg, rd_sh_next;
  logic [4:0] rd_cnt_reg, rd_cnt_next;
  logic rd_bit_reg, rd_bit_next;
  logic fetch_en_reg, fetch_en_next;
  logic [7:0] fetch_addr_reg, fetch_addr_next;
  logic shift_prev_reg;
  logic serial_out_reg, serial_out_next;
  logic oe_reg, oe_next;
  logic commit;
  logic rise;
  logic w16;
  logic [4:0] aw;
  logic [4:0] dw;
  logic [15:0] row_word;
  logic [15:0] fetch_word;
  logic [7:0] fetch_byte;
  logic [15:0] wr_word;
  logic [15:0] mem [0:`SECE_ROWS-1];
  logic buf_flush;

  sece_stream_if #(.WIDTH(16)) fill_if ();
  sece_stream_if #(.WIDTH(16)) drain_if ();

  // ----------------------------------------------------------------
  // Mode and edge
  // ----------------------------------------------------------------
  assign w16 = word_width_strap;
  assign aw = w16 ? 5'(`SECE_AW16) : 5'(`SECE_AW8);
  assign dw = w16 ? 5'(`SECE_DW16) : 5'(`SECE_DW8);
  assign rise = shift_clock && !shift_prev_reg;
  assign commit = busy_reg && (timer_reg == '0);

  // ----------------------------------------------------------------
  // Read fetch into buffer
  // ----------------------------------------------------------------
  // Byte mode: even address in low half of a row
  assign row_word = mem[w16 ? fetch_addr_reg[6:0] : fetch_addr_reg[7:1]];
  assign fetch_byte = fetch_addr_reg[0] ? row_word[15:8] : row_word[7:0];
  assign fetch_word = w16 ? row_word : {fetch_byte, 8'h00};
  assign fill_if.valid = fetch_en_reg;
  assign fill_if.data = fetch_word;
  assign buf_flush = !chip_sel;

  sece_buffer #(.WIDTH(16)) u_buf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .flush(buf_flush),
    .fill(fill_if),
    .drain(drain_if)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [25:0] sh;
    logic [1:0] opc;
    logic [7:0] adr;
    logic [1:0] sp;
    sh = {rx_sh_reg[24:0], serial_in};
    opc = w16 ? sh[8:7] : sh[9:8];
    adr = w16 ? {1'b0, sh[6:0]} : sh[7:0];
    sp = w16 ? adr[6:5] : adr[7:6];
    state_next = state_reg;
    pend_next = pend_reg;
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    unlocked_next = unlocked_reg;
    busy_next = busy_reg;
    timer_next = timer_reg;
    status_next = status_reg;
    rd_sh_next = rd_sh_reg;
    rd_cnt_next = rd_cnt_reg;
    rd_bit_next = rd_bit_reg;
    fetch_en_next = fetch_en_reg;
    fetch_addr_next = fetch_addr_reg;
    drain_if.ready = 1'b0;
    // Self-timed cycle runs without shift clocks
    if (busy_reg) begin
      if (timer_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        timer_next = timer_reg - 1'b1;
      end
    end
    // fetch next word, wrap per mode
    if (fetch_en_reg && fill_if.ready) begin
      fetch_addr_next = w16 ? {1'b0, fetch_addr_reg[6:0] + 7'h01} : fetch_addr_reg + 8'h01;
    end
    if (!chip_sel) begin
      status_next = status_reg;
      fetch_en_next = 1'b0;
      rx_cnt_next = 5'h00;
      state_next = sece_pkg::SECE_ST_IDLE;
      if (state_reg == sece_pkg::SECE_ST_WAITCS && unlocked_reg && !busy_reg) begin
        busy_next = 1'b1;
        timer_next = TW'(PROG_CYCLES - 1);
        status_next = 1'b1;
      end
    end else if (rise) begin
      case (state_reg)
        sece_pkg::SECE_ST_IDLE: begin
          if (serial_in) begin
            status_next = 1'b0;
            if (!busy_reg) begin
              state_next = sece_pkg::SECE_ST_RX;
              rx_sh_next = '0;
              rx_cnt_next = 5'h00;
            end
          end
        end
        sece_pkg::SECE_ST_RX: begin
          rx_sh_next = sh;
          rx_cnt_next = rx_cnt_reg + 5'h01;
          if (rx_cnt_reg + 5'h01 == aw + 5'(`SECE_OPC_BITS)) begin
            addr_next = adr;
            rx_cnt_next = 5'h00;
            case (opc)
              `SECE_OP_READ: begin
                state_next = sece_pkg::SECE_ST_READ;
                rd_bit_next = 1'b0;
                rd_cnt_next = 5'h00;
                fetch_en_next = 1'b1;
                fetch_addr_next = adr;
              end
              `SECE_OP_WRITE: begin
                state_next = sece_pkg::SECE_ST_DATA;
                pend_next = sece_pkg::SECE_PG_WORD_WR;
              end
              `SECE_OP_ERASE: begin
                state_next = sece_pkg::SECE_ST_WAITCS;
                pend_next = sece_pkg::SECE_PG_WORD_ER;
              end
              default: begin
                case (sp)
                  `SECE_SP_UNLOCK: begin
                    unlocked_next = 1'b1;
                    state_next = sece_pkg::SECE_ST_DONE;
                  end
                  `SECE_SP_LOCK: begin
                    unlocked_next = 1'b0;
                    state_next = sece_pkg::SECE_ST_DONE;
                  end
                  `SECE_SP_FILL: begin
                    state_next = sece_pkg::SECE_ST_DATA;
                    pend_next = sece_pkg::SECE_PG_ALL_WR;
                  end
                  default: begin
                    state_next = sece_pkg::SECE_ST_WAITCS;
                    pend_next = sece_pkg::SECE_PG_ALL_ER;
                  end
                endcase
              end
            endcase
          end
        end
        sece_pkg::SECE_ST_DATA: begin
          data_next = {data_reg[14:0], serial_in};
          rx_cnt_next = rx_cnt_reg + 5'h01;
          if (rx_cnt_reg + 5'h01 == dw) begin
            state_next = sece_pkg::SECE_ST_WAITCS;
          end
        end
        sece_pkg::SECE_ST_READ: begin
          if (rd_cnt_reg == 5'h00) begin
            // Stall on empty buffer rather than emit stale data
            if (drain_if.valid) begin
              drain_if.ready = 1'b1;
              rd_bit_next = drain_if.data[15];
              rd_sh_next = {drain_if.data[14:0], 1'b0};
              rd_cnt_next = dw - 5'h01;
            end
          end else begin
            rd_bit_next = rd_sh_reg[15];
            rd_sh_next = {rd_sh_reg[14:0], 1'b0};
            rd_cnt_next = rd_cnt_reg - 5'h01;
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
    oe_next = chip_sel && ((state_next == sece_pkg::SECE_ST_READ) ||
              (status_next && state_next == sece_pkg::SECE_ST_IDLE));
    serial_out_next = (state_next == sece_pkg::SECE_ST_READ) ? rd_bit_next : !busy_next;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= sece_pkg::SECE_ST_IDLE;
      pend_reg <= sece_pkg::SECE_PG_NONE;
      rx_sh_reg <= '0;
      rx_cnt_reg <= 5'h00;
      addr_reg <= 8'h00;
      data_reg <= 16'h0000;
      unlocked_reg <= 1'b0;
      busy_reg <= 1'b0;
      timer_reg <= '0;
      status_reg <= 1'b0;
      rd_sh_reg <= 16'h0000;
      rd_cnt_reg <= 5'h00;
      rd_bit_reg <= 1'b0;
      fetch_en_reg <= 1'b0;
      fetch_addr_reg <= 8'h00;
      shift_prev_reg <= 1'b0;
      serial_out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      rx_sh_reg <= rx_sh_next;
      rx_cnt_reg <= rx_cnt_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      unlocked_reg <= unlocked_next;
      busy_reg <= busy_next;
      timer_reg <= timer_next;
      status_reg <= status_next;
      rd_sh_reg <= rd_sh_next;
      rd_cnt_reg <= rd_cnt_next;
      rd_bit_reg <= rd_bit_next;
      fetch_en_reg <= fetch_en_next;
      fetch_addr_reg <= fetch_addr_next;
      shift_prev_reg <= shift_clock;
      serial_out_reg <= serial_out_next;
      oe_reg <= oe_next;
    end
  end

  assign serial_out = serial_out_reg;
  assign serial_out_oe = oe_reg;
  assign busy = busy_reg;

  // ----------------------------------------------------------------
  // Array update at end of cycle
  // ----------------------------------------------------------------
  // erase-then-program folds into one final value
  always_comb begin
    wr_word = `SECE_ERASED_WORD;
    if (pend_reg == sece_pkg::SECE_PG_WORD_WR || pend_reg == sece_pkg::SECE_PG_ALL_WR) begin
      wr_word = w16 ? data_reg : {data_reg[7:0], data_reg[7:0]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SECE_ROWS; g = g + 1) begin : g_row
      logic hit;
      logic all;
      logic [15:0] nv;
      assign all = (pend_reg == sece_pkg::SECE_PG_ALL_WR) || (pend_reg == sece_pkg::SECE_PG_ALL_ER);
      assign hit = all || (w16 ? (addr_reg[6:0] == 7'(g)) : (addr_reg[7:1] == 7'(g)));
      assign nv = (w16 || all) ? wr_word :
                  (addr_reg[0] ? {wr_word[7:0], mem[g][7:0]} : {mem[g][15:8], wr_word[7:0]});
      always_ff @(posedge clk_sys) begin
        if (clk_en && commit && hit) begin
          mem[g] <= nv;
        end
      end
    end
  endgenerate
endmodule : sece_command_engine
`default_nettype wire

// *** verif/sece_engine_monitor.sv ***
// Concurrent checks on the command engine ports
`timescale 1ns/100ps
`default_nettype none
module sece_engine_monitor #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic chip_sel,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic word_width_strap,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----
  // Helpers
  // ----
  logic shift_q;
  logic rise_q;
  logic [31:0] cnt;
  // Edge memory follows clk_en, as the engine freezes its own copy
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      shift_q <= shift_clock;
      rise_q <= shift_clock && !shift_q;
    end
    cnt <= (sys_rst || !busy) ? 32'h0 : cnt + 32'(clk_en);
  end
  sequence s_busy_run;
    busy [*8];
  endsequence
  sequence s_done_show;
    ##[0:2] serial_out;
  endsequence
  // ----
  // Properties
  // ----
  property p_oe_off;
    !chip_sel && clk_en |=> !serial_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven after deselect");
  property p_busy_cause;
    $rose(busy) |-> !$past(chip_sel);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without deselect");
  property p_busy_len;
    $fell(busy) |-> cnt == PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("program cycle length wrong");
  property p_busy_run;
    $rose(busy) |-> s_busy_run;
  endproperty
  a_busy_run: assert property (p_busy_run) else $error("program cycle cut short");
  property p_status_show;
    $rose(chip_sel) && busy && clk_en && !shift_clock |=> serial_out_oe;
  endproperty
  a_status_show: assert property (p_status_show) else $error("status not shown");
  property p_status_busy;
    serial_out_oe && busy && $past(busy) |-> !serial_out;
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("busy status not 0");
  property p_status_done;
    $fell(busy) && serial_out_oe && chip_sel |-> s_done_show;
  endproperty
  a_status_done: assert property (p_status_done) else $error("ready status not 1");
  property p_hold;
    chip_sel && $past(chip_sel) && clk_en && !(shift_clock && !shift_q) && !rise_q && !busy && !$past(busy)
      |=> $stable(serial_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without clock");
  property p_freeze;
    !clk_en |=> $stable(serial_out) && $stable(serial_out_oe) && $stable(busy);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : sece_engine_monitor
bind sece_command_engine sece_engine_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.clk_sys, .sys_rst, .clk_en,
  .chip_sel, .shift_clock, .serial_in, .word_width_strap, .serial_out, .serial_out_oe, .busy);
`default_nettype wire

// *** verif/sece_host_model.sv ***
// Host controller model on the three-wire serial bus
`timescale 1ns/100ps
`default_nettype none
module sece_host_model (
  input wire logic clk_sys,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic chip_sel,
  output logic shift_clock,
  output logic serial_in
);
  int gap = 0;
  initial begin
    chip_sel = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end
  // Undriven output reads as z so a missing enable never matches
  function automatic logic line();
    return serial_out_oe ? serial_out : 1'bz;
  endfunction : line
  // Don't-care bits toggle, so a stale level is never mistaken for data
  task automatic xfer(input logic b, output logic o);
    @(negedge clk_sys);
    shift_clock = 1'b0;
    serial_in = (b === 1'bx) ? ~serial_in : b;
    repeat (gap + 1) @(negedge clk_sys);
    shift_clock = 1'b1;
    repeat (3) @(negedge clk_sys);
    o = line();
  endtask : xfer
  task automatic command(input int lead, input logic [1:0] opc, input logic [7:0] a, input int aw,
                         input logic [15:0] d, input int dw, output logic o);
    @(negedge clk_sys);
    chip_sel = 1'b1;
    repeat (lead) xfer(1'b0, o);
    xfer(1'b1, o);
    xfer(opc[1], o);
    xfer(opc[0], o);
    for (int i = aw - 1; i >= 0; i--) xfer(a[i], o);
    for (int i = dw - 1; i >= 0; i--) xfer(d[i], o);
  endtask : command
  task automatic fetch(input int n, output logic [15:0] v);
    logic o;
    v = 16'h0;
    for (int i = 0; i < n; i++) begin
      xfer(1'bx, o);
      v = {v[14:0], o};
    end
  endtask : fetch
  task automatic poll(output logic o);
    @(negedge clk_sys);
    chip_sel = 1'b1;
    repeat (2) @(negedge clk_sys);
    o = line();
  endtask : poll
  // Clock stands still low between frames
  task automatic release_bus();
    @(negedge clk_sys);
    chip_sel = 1'b0;
    shift_clock = 1'b0;
    serial_in = ~serial_in;
    // Two deselected edges, so one lands even across a paused enable
    @(negedge clk_sys);
  endtask : release_bus
endmodule : sece_host_model
`default_nettype wire

// *** verif/serial_eeprom_command_engine_tb.sv ***
// Self-checking bench for the serial EEPROM command engine
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_command_engine_tb;
  localparam int PROG = 20;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic word_width_strap = 1'b1;
  logic stall = 1'b0;
  logic chip_sel, shift_clock, serial_in, serial_out, serial_out_oe, busy;
  logic [31:0] rs = 32'h463;
  logic [15:0] exp_w [128];
  int cyc = 0;
  int n_fail = 0;
  int checks_done = 0;
  always #50 clk_sys = ~clk_sys;
  sece_command_engine #(.PROG_CYCLES(PROG)) dut (.clk_sys, .sys_rst, .clk_en, .chip_sel, .shift_clock,
    .serial_in, .word_width_strap, .serial_out, .serial_out_oe, .busy);
  sece_host_model host (.clk_sys, .serial_out, .serial_out_oe, .chip_sel, .shift_clock, .serial_in);
  // Single-cycle pauses only; a rise still lands unless a pause hits a one-cycle low phase (host.gap 0)
  always @(negedge clk_sys) begin
    cyc++;
    clk_en <= !(stall && clk_en && cyc % 3 == 0);
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic void put(input logic [7:0] a, input logic [15:0] d);
    if (word_width_strap) exp_w[a[6:0]] = d;
    else if (a[0]) exp_w[a[7:1]][15:8] = d[7:0];
    else exp_w[a[7:1]][7:0] = d[7:0];
  endfunction : put
  function automatic void fill(input logic [15:0] d);
    for (int i = 0; i < 256; i++) put(8'(i), d);
  endfunction : fill
  function automatic logic [15:0] want(input logic [7:0] a);
    if (word_width_strap) return exp_w[a[6:0]];
    return a[0] ? {8'h0, exp_w[a[7:1]][15:8]} : {8'h0, exp_w[a[7:1]][7:0]};
  endfunction : want
  function automatic logic [7:0] spa(input logic [1:0] code);
    logic [31:0] r;
    r = rnd();
    return word_width_strap ? {1'b0, code, r[4:0]} : {code, r[5:0]};
  endfunction : spa
  task automatic check(input logic [15:0] seen, input logic [15:0] want_v);
    checks_done++;
    if (seen !== want_v) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want_v);
    end
  endtask : check
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic do_cmd(input logic [1:0] opc, input logic [7:0] a, input logic [15:0] d, input bit dat,
                        input bit prog);
    logic o;
    host.gap = int'(rnd() & 32'h3);
    host.command(int'(rnd() & 32'h3), opc, a, word_width_strap ? 7 : 8, d, dat ? (word_width_strap ? 16 : 8) : 0, o);
    host.release_bus();
    repeat (3) @(negedge clk_sys);
    check(16'(busy), 16'(prog));
    if (prog) begin
      host.poll(o);
      check(16'(o), 16'h0);
      for (int i = 0; i < PROG * 4 && o !== 1'b1; i++) begin
        @(negedge clk_sys);
        o = host.line();
      end
      check(16'(o), 16'h1);
      host.release_bus();
    end
  endtask : do_cmd
  task automatic read_chk(input logic [7:0] a, input int n);
    logic o;
    logic [15:0] v;
    host.gap = int'(rnd() & 32'h3);
    host.command(int'(rnd() & 32'h3), 2'b10, a, word_width_strap ? 7 : 8, 16'h0, 0, o);
    check(16'(o), 16'h0);
    for (int k = 0; k < n; k++) begin
      host.fetch(word_width_strap ? 16 : 8, v);
      check(v, want((a + 8'(k)) & (word_width_strap ? 8'h7f : 8'hff)));
    end
    host.release_bus();
  endtask : read_chk
  // ----
  // Sequence
  // ----
  // About seven times the expected run length
  initial begin
    #5000000;
    n_fail++;
    close_out();
  end
  initial begin
    logic [31:0] r;
    logic [7:0] a;
    logic [7:0] top;
    logic [15:0] d;
    for (int m = 1; m >= 0; m--) begin
      word_width_strap = m[0];
      sys_rst = 1'b1;
      repeat (16) @(negedge clk_sys);
      sys_rst = 1'b0;
      top = m[0] ? 8'h7f : 8'hff;
      check(16'({serial_out_oe, busy}), 16'h0);
      do_cmd(2'b01, 8'h05, 16'h1234, 1'b1, 1'b0);
      do_cmd(2'b00, spa(2'h3), 16'h0, 1'b0, 1'b0);
      do_cmd(2'b00, spa(2'h2), 16'h0, 1'b0, 1'b1);
      fill(16'hffff);
      read_chk(top, 2);
      for (int i = 0; i < 6; i++) begin
        r = rnd();
        a = (i == 0) ? top : (i == 1) ? 8'h0 : r[7:0] & top;
        d = (i == 2) ? 16'h0 : r[31:16];
        do_cmd(2'b01, a, d, 1'b1, 1'b1);
        put(a, d);
      end
      read_chk(top, 3);
      a = 8'(rnd()) & top;
      do_cmd(2'b11, a, 16'h0, 1'b0, 1'b1);
      put(a, 16'hffff);
      read_chk(a, 1);
      stall = 1'b1;
      read_chk(8'(rnd()) & top, 4);
      stall = 1'b0;
      d = 16'(rnd());
      do_cmd(2'b00, spa(2'h1), d, 1'b1, 1'b1);
      fill(d);
      read_chk(8'(rnd()) & top, 2);
      do_cmd(2'b00, spa(2'h0), 16'h0, 1'b0, 1'b0);
      do_cmd(2'b11, a, 16'h0, 1'b0, 1'b0);
      read_chk(a, 1);
    end
    close_out();
  end
endmodule : serial_eeprom_command_engine_tb
`default_nettype wire
